// >>> logic/buck3_config.sv
`timescale 1ns/1ps
// Operation
// - The 7-bit ON voltage code maps to 0.85V plus 25mV per code step, saturating at 3.4V from code 0x66 up.
// - A configuration-memory load sets ON code bits 6:2 and clears bits 1:0, giving 100mV resolution.
// - The ON code is held as fields 6:2 and 1:0 forming one code, both reset to zero.
// - Sleep timeslot field resets to 000; 000, 110, 111 move to SLEEP settings in slot 5, 3, 1.
// - Sleep timeslot codes 001 to 101 disable the converter in slot 5, 4, 3, 2, 1.
// - Under a hardware enable input, codes 001 to 101 pick the slot for entering SLEEP instead.
// - Sleep mode bits 9:8 select FCCM, auto, LDO or hysteretic, defaulting to hysteretic.
// - Sleep voltage bits 6:0 use the ON code encoding and reset to zero.
// - Under hardware control a choice bit selects the ON code (0) or SLEEP code (1).
// - ON timeslot 001 to 101 enables in slot 1 to 5, 000 never, 110/111 hand over to hw enable 1/2.
module buck3_config
    import buck3_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire seq_evt_t         seq_evt,
    input  wire logic             cfg_load,
    input  wire logic [4:0]       cfg_vsel,
    input  wire logic             hw_enable1,
    input  wire logic             hw_enable2,
    output conv_out_t             conv_out
);

    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
        logic [15:0] on_cfg;
        logic [15:0] slp_cfg;
        logic [15:0] hw_cfg;
        logic [1:0]  hw_meta;
        logic [1:0]  hw_sync;
        conv_state_t state;
        conv_out_t   out;
    } state_t;

    localparam state_t ST_RESET = '{
        ack:     1'b0,
        rdata:   16'h0000,
        on_cfg:  ON_CFG_RST,
        slp_cfg: SLP_CFG_RST,
        hw_cfg:  16'h0000,
        hw_meta: 2'b00,
        hw_sync: 2'b00,
        state:   ST_OFF,
        // Idle output already shows the ON defaults, so code and millivolts agree
        out:     '{1'b0, 1'b0, 7'h00, ON_CFG_RST[MODE_LSB +: 2], VOLT_BASE_MV}
    };

    state_t      st;
    state_t      next;
    logic [6:0]  sel_code;
    logic [11:0] sel_mv;

    // ------------------------------------------------------------
    // Decoded fields of the current state and of the bus request
    // ------------------------------------------------------------
    logic [2:0]  on_slot;
    logic [2:0]  slp_slot;
    logic [2:0]  slp_target;
    logic        slp_disable;
    logic        hwc;
    logic        hw_en;
    logic        vchoice;
    logic [15:0] wmask;
    logic        bus_req;
    logic [15:0] idx;

    assign on_slot = st.on_cfg[SLOT_LSB +: 3];
    assign slp_slot = st.slp_cfg[SLOT_LSB +: 3];
    assign vchoice = st.hw_cfg[VCHOICE_BIT];
    assign hwc = (on_slot == SLOT_HW1) || (on_slot == SLOT_HW2);
    assign hw_en = (on_slot == SLOT_HW1) ? st.hw_sync[0] : st.hw_sync[1];
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign idx = wb_adr_i[ADR_W-1:2];

    always_comb begin
        slp_disable = (slp_slot >= SLOT_FIRST) && (slp_slot <= SLOT_LAST);
        case (slp_slot)
            3'h0: slp_target = SLP_TS5;
            3'h6: slp_target = SLP_TS3;
            3'h7: slp_target = SLP_TS1;
            default: slp_target = SLP_DIS_SUM - slp_slot;
        endcase
    end

    buck_code_decode #(
        .CODE_W(7)
    ) u_decode (
        .code    (sel_code),
        .sat_code(),
        .mv      (sel_mv)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next = st;
        // Two flops per pin; only the second stage is used
        next.hw_meta = {hw_enable2, hw_enable1};
        next.hw_sync = st.hw_meta;

        // Ack lasts one cycle; the write lands on the acked edge
        next.ack = bus_req && !st.ack;
        next.rdata = 16'h0000;
        if (bus_req && !st.ack && !wb_we_i) begin
            case (idx)
                IDX_ON_CONFIG:  next.rdata = st.on_cfg;
                IDX_SLEEP_CTRL: next.rdata = st.slp_cfg;
                IDX_HW_CTRL:    next.rdata = st.hw_cfg;
                IDX_STATUS:     next.rdata = {1'b0, st.out.code, 5'h00, hw_en, st.out.asleep, st.out.enable};
                default:        next.rdata = 16'h0000;
            endcase
        end
        if (bus_req && st.ack && wb_we_i) begin
            case (idx)
                IDX_ON_CONFIG:  next.on_cfg = (st.on_cfg & ~(wmask & ON_RW_MASK)) |
                                              (wb_dat_i[15:0] & wmask & ON_RW_MASK);
                IDX_SLEEP_CTRL: next.slp_cfg = (st.slp_cfg & ~(wmask & SLP_RW_MASK)) |
                                               (wb_dat_i[15:0] & wmask & SLP_RW_MASK);
                IDX_HW_CTRL:    next.hw_cfg = (st.hw_cfg & ~(wmask & HW_RW_MASK)) |
                                              (wb_dat_i[15:0] & wmask & HW_RW_MASK);
                default:        next.hw_cfg = st.hw_cfg;
            endcase
        end
        if (cfg_load) begin
            next.on_cfg[VSEL_HI_LSB +: 5] = cfg_vsel;
            next.on_cfg[VSEL_LSB +: 2] = 2'b00;
        end

        case (st.state)
            ST_OFF: begin
                if (hwc && hw_en) begin
                    next.state = ST_ON;
                end else if (!hwc && seq_evt.start_slot && (on_slot != SLOT_NONE) && (seq_evt.slot == on_slot)) begin
                    next.state = ST_ON;
                end
            end
            ST_ON: begin
                if (hwc && !hw_en) begin
                    next.state = ST_OFF;
                end else if (seq_evt.sleep_slot && (seq_evt.slot == slp_target)) begin
                    next.state = (slp_disable && !hwc) ? ST_OFF : ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (hwc && !hw_en) begin
                    next.state = ST_OFF;
                end else if (seq_evt.wake) begin
                    next.state = ST_ON;
                end
            end
            default: next.state = ST_OFF;
        endcase

        if (next.state == ST_SLEEP) begin
            sel_code = next.slp_cfg[VSEL_LSB +: 7];
            next.out.mode = next.slp_cfg[MODE_LSB +: 2];
        end else begin
            sel_code = (next.on_cfg[SLOT_LSB +: 3] >= SLOT_HW1 && next.hw_cfg[VCHOICE_BIT]) ?
                       next.slp_cfg[VSEL_LSB +: 7] : next.on_cfg[VSEL_LSB +: 7];
            next.out.mode = next.on_cfg[MODE_LSB +: 2];
        end
        next.out.code = sel_code;
        next.out.mv = sel_mv;
        next.out.enable = (next.state != ST_OFF);
        next.out.asleep = (next.state == ST_SLEEP);
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= ST_RESET;
        end else begin
            st <= next;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = {16'h0000, st.rdata};
    assign conv_out = st.out;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_mv_linear: assert property (@(posedge core_clk) disable iff (!rstn)
        (st.out.code < VOLT_CODE_SAT) |-> (st.out.mv == VOLT_BASE_MV + 12'({5'h00, st.out.code} * VOLT_STEP_MV)))
        else $error("Output millivolts not linear in code");
    a_mv_saturate: assert property (@(posedge core_clk) disable iff (!rstn)
        (st.out.code >= VOLT_CODE_SAT) |-> (st.out.mv == 12'h0d48))
        else $error("Top codes do not saturate at 3.4V");
    a_cfg_load: assert property (@(posedge core_clk) disable iff (!rstn)
        cfg_load |=> (st.on_cfg[6:0] == {$past(cfg_vsel), 2'b00}))
        else $error("Config load did not set upper code bits");
    a_reset_on: assert property (@(posedge core_clk)
        (rstn && $past(!rstn)) |-> (st.on_cfg[6:0] == 7'h00 && !st.out.enable))
        else $error("ON code not zero after reset");
    a_reset_slot: assert property (@(posedge core_clk)
        (rstn && $past(!rstn)) |-> (slp_slot == 3'h0 && slp_target == 3'h5))
        else $error("Sleep slot default wrong");
    a_sleep_disable: assert property (@(posedge core_clk) disable iff (!rstn)
        (st.state == ST_ON && !hwc && slp_disable && seq_evt.sleep_slot && seq_evt.slot == slp_target)
        |=> (st.state == ST_OFF && !st.out.enable && !st.out.asleep))
        else $error("Converter not disabled in its sleep slot");
    a_hw_sleep: assert property (@(posedge core_clk) disable iff (!rstn)
        (st.state == ST_ON && hwc && hw_en && slp_disable && seq_evt.sleep_slot && seq_evt.slot == slp_target)
        |=> st.out.asleep && st.out.enable)
        else $error("Hardware-controlled converter did not enter sleep");
    a_reset_mode: assert property (@(posedge core_clk)
        (rstn && $past(!rstn)) |-> (st.slp_cfg[9:8] == 2'h3 && st.on_cfg[9:8] == 2'h1))
        else $error("Mode defaults wrong after reset");
    a_reset_sleepv: assert property (@(posedge core_clk)
        (rstn && $past(!rstn)) |-> (st.slp_cfg[6:0] == 7'h00))
        else $error("Sleep code not zero after reset");
    a_hw_choice: assert property (@(posedge core_clk) disable iff (!rstn)
        (st.state == ST_ON && hwc) |-> (st.out.code == (vchoice ? st.slp_cfg[6:0] : st.on_cfg[6:0])))
        else $error("Voltage choice not followed");
    a_on_slot: assert property (@(posedge core_clk) disable iff (!rstn)
        (st.state == ST_OFF && on_slot == SLOT_NONE) |=> (st.state == ST_OFF))
        else $error("Converter enabled with ON slot 000");
    a_wake: assert property (@(posedge core_clk) disable iff (!rstn)
        (st.state == ST_SLEEP && seq_evt.wake && !(hwc && !hw_en))
        |=> (st.state == ST_ON && st.out.mode == st.on_cfg[9:8]))
        else $error("Wake did not restore ON settings");

endmodule

// >>> common/buck3_pkg.sv
package buck3_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int          ADR_W           = 18;
    localparam logic [15:0] IDX_ON_CONFIG   = 16'h4062;
    localparam logic [15:0] IDX_SLEEP_CTRL  = 16'h4063;
    localparam logic [15:0] IDX_HW_CTRL     = 16'h4070;
    localparam logic [15:0] IDX_STATUS      = 16'h4071;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          SLOT_LSB        = 13;
    localparam int          MODE_LSB        = 8;
    localparam int          VSEL_LSB        = 0;
    localparam int          VSEL_HI_LSB     = 2;
    localparam int          VCHOICE_BIT     = 0;
    localparam int          ST_CODE_LSB     = 8;
    localparam logic [15:0] ON_RW_MASK      = 16'he37f;
    localparam logic [15:0] SLP_RW_MASK     = 16'he37f;
    localparam logic [15:0] HW_RW_MASK      = 16'h0001;
    localparam logic [15:0] ON_CFG_RST      = 16'h0100;
    localparam logic [15:0] SLP_CFG_RST     = 16'h0300;

    // ------------------------------------------------------------
    // Timeslot codes
    // ------------------------------------------------------------
    localparam logic [2:0]  SLOT_NONE       = 3'h0;
    localparam logic [2:0]  SLOT_FIRST      = 3'h1;
    localparam logic [2:0]  SLOT_LAST       = 3'h5;
    localparam logic [2:0]  SLOT_HW1        = 3'h6;
    localparam logic [2:0]  SLOT_HW2        = 3'h7;
    localparam logic [2:0]  SLP_TS5         = 3'h5;
    localparam logic [2:0]  SLP_TS3         = 3'h3;
    localparam logic [2:0]  SLP_TS1         = 3'h1;
    localparam logic [2:0]  SLP_DIS_SUM     = 3'h6;

    // ------------------------------------------------------------
    // Voltage code scale
    // ------------------------------------------------------------
    localparam logic [11:0] VOLT_BASE_MV    = 12'h0352;
    localparam logic [11:0] VOLT_STEP_MV    = 12'h0019;
    localparam logic [6:0]  VOLT_CODE_SAT   = 7'h66;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_FCCM = 2'h0,
        MODE_AUTO = 2'h1,
        MODE_LDO  = 2'h2,
        MODE_HYST = 2'h3
    } conv_mode_t;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b001,
        ST_ON    = 3'b010,
        ST_SLEEP = 3'b100
    } conv_state_t;

    // Sequencer events, one-cycle strobes
    typedef struct packed {
        logic       start_slot;
        logic       sleep_slot;
        logic [2:0] slot;
        logic       wake;
    } seq_evt_t;

    // Settings presented to the converter stage
    typedef struct packed {
        logic        enable;
        logic        asleep;
        logic [6:0]  code;
        logic [1:0]  mode;
        logic [11:0] mv;
    } conv_out_t;

endpackage

// >>> logic/buck_code_decode.sv
`timescale 1ns/1ps
module buck_code_decode
    import buck3_pkg::*;
#(
    parameter int CODE_W = 7
) (
    input  wire logic [CODE_W-1:0] code,
    output logic      [CODE_W-1:0] sat_code,
    output logic      [11:0]       mv
);

    generate
        if (CODE_W != 7) begin : g_bad_width
            $error("buck_code_decode supports a 7-bit code only");
        end
    endgenerate

    always_comb begin
        sat_code = (code > VOLT_CODE_SAT) ? VOLT_CODE_SAT : code;
        mv = VOLT_BASE_MV + 12'({5'h00, sat_code} * VOLT_STEP_MV);
    end

endmodule

// >>> test/buck3_seq_model.sv
`timescale 1ns/1ps
module buck3_seq_model
    import buck3_pkg::*;
(
    input  wire logic core_clk,
    output seq_evt_t  seq_evt,
    output logic      hw_enable1,
    output logic      hw_enable2
);
    initial begin
        seq_evt    = '0;
        hw_enable1 = 1'b0;
        hw_enable2 = 1'b0;
    end

    // One-cycle strobe: kind 0 start, 1 sleep, 2 wake
    task automatic pulse(input int kind, input logic [2:0] slot);
        @(posedge core_clk);
        seq_evt <= '{kind == 0, kind == 1, slot, kind == 2};
        @(posedge core_clk);
        // Slot is not held once the strobe drops
        seq_evt <= '{1'b0, 1'b0, ~slot, 1'b0};
    endtask

    task automatic pin(input int n, input logic v);
        @(posedge core_clk);
        if (n == 1) begin
            hw_enable1 <= v;
        end else begin
            hw_enable2 <= v;
        end
    endtask
endmodule

// >>> test/buck3_config_test.sv
`timescale 1ns/1ps
module buck3_config_test
    import buck3_pkg::*;
;
    logic             core_clk;
    logic             rstn;
    logic             wb_cyc_i;
    logic             wb_stb_i;
    logic             wb_we_i;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0]       wb_sel_i;
    logic [31:0]      wb_dat_i;
    logic [31:0]      wb_dat_o;
    logic             wb_ack_o;
    seq_evt_t         seq_evt;
    logic             cfg_load;
    logic [4:0]       cfg_vsel;
    logic             hw_enable1;
    logic             hw_enable2;
    conv_out_t        conv_out;
    int               mismatches;
    int               samples_checked;
    logic [31:0]      rdat;
    logic [2:0]       sc;
    logic [2:0]       ts;
    logic [6:0]       vc;
    logic             asl;
    logic [6:0]       codes [5] = '{7'h00, 7'h01, 7'h65, 7'h66, 7'h7f};

    buck3_config buck3_config_i (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .seq_evt  (seq_evt),
        .cfg_load (cfg_load),
        .cfg_vsel (cfg_vsel),
        .hw_enable1(hw_enable1),
        .hw_enable2(hw_enable2),
        .conv_out (conv_out)
    );

    buck3_seq_model buck3_seq_model_i (
        .core_clk  (core_clk),
        .seq_evt   (seq_evt),
        .hw_enable1(hw_enable1),
        .hw_enable2(hw_enable2)
    );

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    function automatic conv_out_t co(logic en, logic sl, logic [6:0] c, logic [1:0] m);
        logic [6:0] s;
        s  = (c > 7'h65) ? 7'h66 : c;
        co = '{en, sl, c, m, VOLT_BASE_MV + VOLT_STEP_MV * {5'h00, s}};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic we, input logic [15:0] idx, input logic [15:0] d);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0000, d};
        n = 0;
        // No bound here: a lost ack is caught by the watchdog
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        chk("ack latency", 32'h0000_0002, 32'(n));
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk($sformatf("reg %h", idx), exp, rdat);
    endtask

    task automatic out(input conv_out_t e);
        repeat (2) @(posedge core_clk);
        chk("conv_out", {9'h000, e}, {9'h000, conv_out});
    endtask

    task automatic ev(input int k, input logic [2:0] s, input conv_out_t e);
        buck3_seq_model_i.pulse(k, s);
        out(e);
    endtask

    task automatic wait_en(input logic v);
        for (int n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (conv_out.enable === v) break;
        end
        chk("enable", {31'h0, v}, {31'h0, conv_out.enable});
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        #(40 * 5000);
        mismatches++;
        finish_test();
    end

    initial begin
        rstn = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = '0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        cfg_load = 1'b0;
        cfg_vsel = 5'h00;
        mismatches = 0;
        samples_checked = 0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rd(IDX_ON_CONFIG, 32'h0000_0100);
        rd(IDX_SLEEP_CTRL, 32'h0000_0300);
        rd(IDX_HW_CTRL, 32'h0000_0000);
        out(co(1'b0, 1'b0, 7'h00, 2'h1));
        wr(IDX_SLEEP_CTRL, 16'hffff);
        rd(IDX_SLEEP_CTRL, 32'h0000_e37f);
        rd(16'h4000, 32'h0000_0000);
        @(posedge core_clk);
        cfg_load <= 1'b1;
        cfg_vsel <= 5'h1f;
        @(posedge core_clk);
        cfg_load <= 1'b0;
        rd(IDX_ON_CONFIG, 32'h0000_017c);
        wr(IDX_ON_CONFIG, 16'h207f);
        ev(0, 3'h2, co(1'b0, 1'b0, 7'h7f, 2'h0));
        ev(0, 3'h1, co(1'b1, 1'b0, 7'h7f, 2'h0));
        for (int c = 0; c < 8; c++) begin
            sc  = 3'(c);
            vc  = 7'h60 + 7'(c);
            ts  = (sc == 3'h0) ? 3'h5 : (sc == 3'h6) ? 3'h3 : (sc == 3'h7) ? 3'h1 : 3'h6 - sc;
            asl = (sc == 3'h0) || (sc > 3'h5);
            wr(IDX_SLEEP_CTRL, {sc, 3'h0, sc[1:0], 1'b0, vc});
            ev(1, (ts == 3'h5) ? 3'h4 : ts + 3'h1, co(1'b1, 1'b0, 7'h7f, 2'h0));
            ev(1, ts, asl ? co(1'b1, 1'b1, vc, sc[1:0]) : co(1'b0, 1'b0, 7'h7f, 2'h0));
            ev(asl ? 2 : 0, asl ? 3'h0 : 3'h1, co(1'b1, 1'b0, 7'h7f, 2'h0));
        end
        foreach (codes[i]) begin
            wr(IDX_ON_CONFIG, {9'h040, codes[i]});
            out(co(1'b1, 1'b0, codes[i], 2'h0));
        end
        wr(IDX_HW_CTRL, 16'h0001);
        wr(IDX_SLEEP_CTRL, 16'h4042);
        wr(IDX_ON_CONFIG, 16'hc001);
        buck3_seq_model_i.pin(1, 1'b1);
        wait_en(1'b1);
        out(co(1'b1, 1'b0, 7'h42, 2'h0));
        ev(1, 3'h4, co(1'b1, 1'b1, 7'h42, 2'h0));
        buck3_seq_model_i.pin(1, 1'b0);
        wait_en(1'b0);
        wr(IDX_ON_CONFIG, 16'he001);
        buck3_seq_model_i.pin(2, 1'b1);
        wait_en(1'b1);
        rd(IDX_STATUS, 32'h0000_4205);
        wr(IDX_HW_CTRL, 16'h0000);
        out(co(1'b1, 1'b0, 7'h01, 2'h0));
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rd(IDX_ON_CONFIG, 32'h0000_0100);
        rd(IDX_SLEEP_CTRL, 32'h0000_0300);
        out(co(1'b0, 1'b0, 7'h00, 2'h1));
        finish_test();
    end
endmodule
